// *** rtl/rfmc_mode_ctrl.sv ***
// Operating mode, transmitter and receiver control of the reader front end, with an AXI4-Lite register slave.
//
// Contract
// - Power-up clears the whole operating-mode register, giving power-down.
// - Register writes keep working in power-down mode.
// - Bit 7 of operating-mode enables oscillator and regulators, giving ready mode.
// - An interrupt is raised once the oscillator is stable after ready.
// - Receiver and transmitter have independent enable bits.
// - Wake-up bit alone selects wake-up mode with RC oscillator and timer.
// - In wake-up mode a measurement difference raises an interrupt.
// - Single-driver bit set drives only one antenna output.
// - Eight segments per driver; normal-level register selects them, all on by default.
// - In single mode the output-select bit chooses which antenna output drives.
// - Modulation-type bit selects AM or OOK.
// - OOK stops the carrier; fast-decay bit tristates drivers instead.
// - AM turns segments off; calibrate command sets level from target depth.
// - One bit enables one or both channels, another picks auto or manual.
// - With both channels and auto choice, framing picks the channel.
// - Receive window opens automatically when the mask timer expires.
// - Mask and unmask commands force the receive window low or high.
// - Demodulator-select bit picks peak detector or mixer.
// - External-demodulation bit routes receiver inputs straight to gain stage.
`timescale 1ns/1ps
`include "rfmc_params.svh"
module rfmc_mode_ctrl
	import rfmc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic osc_amp_ok,
	input wire logic wake_meas_differs,
	input wire logic tx_mod,
	input wire logic tx_frame_done,
	input wire logic rx_pick_pm,
	output logic osc_reg_en,
	output logic rc_osc_en,
	output logic wake_meas_start,
	output logic rx_power_en,
	output logic am_chan_en,
	output logic pm_chan_en,
	output logic rx_use_pm,
	output logic demod_mixer_sel,
	output logic lf_ext_route,
	output logic rx_on,
	output logic driver_regulated_supply_slow,
	output logic [7:0] antenna_driver_out_a,
	output logic antenna_driver_out_a_oe,
	output logic [7:0] antenna_driver_out_b,
	output logic antenna_driver_out_b_oe,
	output logic irq
);
	rfmc_byte_t opctl_r, iocfg1_r, iocfg2_r, auxdef_r, norm_r, depth_r;
	rfmc_byte_t rxcfg1_r, rxcfg2_r, masktmr_r, waketmr_r, am_lvl_r;
	logic [1:0] flag_r;
	logic [1:0] flag_nxt;
	logic rx_on_r;
	logic rx_on_nxt;
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic [7:0] waddr_r;
	logic [7:0] wbyte_r;
	logic wstb_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic [7:0] seg_a_r, seg_b_r;
	logic oe_a_r, oe_b_r;
	logic aw_now, w_now, wr_fire, rd_fire, wr_sel;
	logic [7:0] wr_addr;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;
	logic cmd_mask, cmd_unmask, cmd_calib, st_clear;
	logic tx_active, modulated, use_a, use_b, drive_on;
	logic [7:0] seg_now;
	rfmc_mode_t mode;
	rfmc_tmr_if tif ();

	// ****************************************
	// Address decoding
	// ****************************************
	// Shared by the write and read paths; unaligned or unknown offsets answer SLVERR.
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == `RFMC_OFS_OPCTL) || (a == `RFMC_OFS_IOCFG1) || (a == `RFMC_OFS_IOCFG2) ||
			(a == `RFMC_OFS_AUXDEF) || (a == `RFMC_OFS_NORMLVL) || (a == `RFMC_OFS_AMDEPTH) ||
			(a == `RFMC_OFS_RXCFG1) || (a == `RFMC_OFS_RXCFG2) || (a == `RFMC_OFS_CMD) ||
			(a == `RFMC_OFS_MASKTMR) || (a == `RFMC_OFS_WAKETMR) || (a == `RFMC_OFS_STATUS);
	endfunction

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	// Address and data are caught independently, so the master may present them in any order.
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign aw_now = s_axi_awvalid && s_axi_awready;
	assign w_now = s_axi_wvalid && s_axi_wready;
	assign wr_fire = (aw_got_r || aw_now) && (w_got_r || w_now);
	assign wr_addr = aw_got_r ? waddr_r : s_axi_awaddr;
	assign wr_byte = w_got_r ? wbyte_r : s_axi_wdata[7:0];
	assign wr_sel = wr_fire && (w_got_r ? wstb_r : s_axi_wstrb[0]);
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 8'h00;
			wbyte_r <= 8'h00;
			wstb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end else begin
			aw_got_r <= (aw_got_r || aw_now) && !wr_fire;
			w_got_r <= (w_got_r || w_now) && !wr_fire;
			if (aw_now)
				waddr_r <= s_axi_awaddr;
			if (w_now) begin
				wbyte_r <= s_axi_wdata[7:0];
				wstb_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= addr_mapped(wr_addr) ? 2'h0 : 2'h2;
			end else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	assign s_axi_arready = !rvalid_r;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	// The command register is write-only and reads as zero.
	assign rd_byte = (s_axi_araddr == `RFMC_OFS_OPCTL) ? opctl_r :
		(s_axi_araddr == `RFMC_OFS_IOCFG1) ? iocfg1_r :
		(s_axi_araddr == `RFMC_OFS_IOCFG2) ? iocfg2_r :
		(s_axi_araddr == `RFMC_OFS_AUXDEF) ? auxdef_r :
		(s_axi_araddr == `RFMC_OFS_NORMLVL) ? norm_r :
		(s_axi_araddr == `RFMC_OFS_AMDEPTH) ? depth_r :
		(s_axi_araddr == `RFMC_OFS_RXCFG1) ? rxcfg1_r :
		(s_axi_araddr == `RFMC_OFS_RXCFG2) ? rxcfg2_r :
		(s_axi_araddr == `RFMC_OFS_MASKTMR) ? masktmr_r :
		(s_axi_araddr == `RFMC_OFS_WAKETMR) ? waketmr_r :
		(s_axi_araddr == `RFMC_OFS_STATUS) ? {2'h0, mode, rx_on_r, tif.osc_stable, flag_r} :
		8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= 2'h0;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= {24'h00_0000, rd_byte};
			rresp_r <= addr_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
		end else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	// clear at power-up, except normal level, which resets to all segments on
	// writes are accepted in every mode, power-down included, since nothing gates them on the mode.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opctl_r <= `RFMC_RST_OPCTL;
			iocfg1_r <= `RFMC_RST_ZERO;
			iocfg2_r <= `RFMC_RST_ZERO;
			auxdef_r <= `RFMC_RST_ZERO;
			norm_r <= `RFMC_RST_NORMLVL;
			depth_r <= `RFMC_RST_ZERO;
			rxcfg1_r <= `RFMC_RST_ZERO;
			rxcfg2_r <= `RFMC_RST_ZERO;
			masktmr_r <= `RFMC_RST_ZERO;
			waketmr_r <= `RFMC_RST_ZERO;
		end else if (wr_sel) begin
			if (wr_addr == `RFMC_OFS_OPCTL) opctl_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_IOCFG1) iocfg1_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_IOCFG2) iocfg2_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_AUXDEF) auxdef_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_NORMLVL) norm_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_AMDEPTH) depth_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_RXCFG1) rxcfg1_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_RXCFG2) rxcfg2_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_MASKTMR) masktmr_r <= wr_byte;
			if (wr_addr == `RFMC_OFS_WAKETMR) waketmr_r <= wr_byte;
		end
	end

	// ****************************************
	// Operating mode and events
	// ****************************************
	// oscillator enable gives ready
	// wake-up only when every other operating bit is clear.
	assign mode = opctl_r[`RFMC_OP_OSC_EN] ? mode_ready :
		(opctl_r == (8'h01 << `RFMC_OP_WAKEUP)) ? mode_wakeup : mode_power_down;
	assign osc_reg_en = (mode == mode_ready);
	assign rc_osc_en = (mode == mode_wakeup);
	assign cmd_mask = wr_sel && (wr_addr == `RFMC_OFS_CMD) && wr_byte[`RFMC_CMD_MASK];
	assign cmd_unmask = wr_sel && (wr_addr == `RFMC_OFS_CMD) && wr_byte[`RFMC_CMD_UNMASK];
	assign cmd_calib = wr_sel && (wr_addr == `RFMC_OFS_CMD) && wr_byte[`RFMC_CMD_CALIB];
	assign st_clear = wr_sel && (wr_addr == `RFMC_OFS_STATUS);
	// sticky event flags; a new event wins over a write-one clear in the same cycle.
	assign flag_nxt[`RFMC_ST_OSC_FLAG] = tif.osc_ready ||
		(flag_r[`RFMC_ST_OSC_FLAG] && !(st_clear && wr_byte[`RFMC_ST_OSC_FLAG]));
	assign flag_nxt[`RFMC_ST_WAKE_FLAG] = tif.wake_hit ||
		(flag_r[`RFMC_ST_WAKE_FLAG] && !(st_clear && wr_byte[`RFMC_ST_WAKE_FLAG]));
	assign irq = |flag_r;
	assign wake_meas_start = tif.wake_meas_start;

	// Timer unit hookup; both pins enter through its synchronisers.
	assign tif.osc_en = osc_reg_en;
	assign tif.wake_mode = rc_osc_en;
	assign tif.wake_period = waketmr_r;
	assign tif.mask_len = masktmr_r;
	assign tif.mask_start = tx_frame_done;
	assign tif.pin_in = {wake_meas_differs, osc_amp_ok};
	rfmc_timer_unit u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.t(tif.tmr)
	);

	// ****************************************
	// Receiver control
	// ****************************************
	// receiver power follows its own enable, and only in ready mode
	assign rx_power_en = osc_reg_en && opctl_r[`RFMC_OP_RX_EN];
	assign am_chan_en = rx_power_en;
	assign pm_chan_en = rx_power_en && opctl_r[`RFMC_OP_RX_CHN];
	assign rx_use_pm = pm_chan_en && !opctl_r[`RFMC_OP_RX_MAN] && rx_pick_pm;
	assign demod_mixer_sel = rxcfg1_r[`RFMC_RX1_MIXER];
	assign lf_ext_route = rxcfg2_r[`RFMC_RX2_LF_EXT];
	// receive window; a command beats a timer expiry, mask beats unmask.
	assign rx_on_nxt = cmd_mask ? 1'b0 : cmd_unmask ? 1'b1 : tx_frame_done ? 1'b0 :
		tif.mask_expired ? 1'b1 : rx_on_r;
	assign rx_on = rx_on_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_r <= 2'h0;
			rx_on_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			rx_on_r <= rx_on_nxt;
		end
	end

	// ****************************************
	// Transmitter control
	// ****************************************
	// transmitter runs on its own enable
	assign tx_active = osc_reg_en && opctl_r[`RFMC_OP_TX_EN];
	assign modulated = tx_active && tx_mod;
	assign use_a = tx_active && !(iocfg1_r[`RFMC_IO1_SINGLE] && iocfg1_r[`RFMC_IO1_ALT_OUT]);
	assign use_b = tx_active && (!iocfg1_r[`RFMC_IO1_SINGLE] || iocfg1_r[`RFMC_IO1_ALT_OUT]);
	// segment pattern: normal level, AM level, or all off for OOK.
	assign seg_now = !modulated ? norm_r : auxdef_r[`RFMC_AUX_MOD_AM] ? am_lvl_r : 8'h00;
	// fast decay releases the pins during an OOK pause.
	assign drive_on = !(modulated && !auxdef_r[`RFMC_AUX_MOD_AM] && auxdef_r[`RFMC_AUX_FAST_DECAY]);
	assign driver_regulated_supply_slow = iocfg2_r[`RFMC_IO2_SLOW_UP];
	assign antenna_driver_out_a = seg_a_r;
	assign antenna_driver_out_b = seg_b_r;
	assign antenna_driver_out_a_oe = oe_a_r;
	assign antenna_driver_out_b_oe = oe_b_r;

	// calibration keeps only the normal-level segments not named in the depth mask.
	// The depth register therefore names segments, which trades accuracy for a closed-form result.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			am_lvl_r <= `RFMC_RST_AMLVL;
			seg_a_r <= 8'h00;
			seg_b_r <= 8'h00;
			oe_a_r <= 1'b0;
			oe_b_r <= 1'b0;
		end else begin
			if (cmd_calib)
				am_lvl_r <= norm_r & ~depth_r;
			seg_a_r <= use_a ? seg_now : 8'h00;
			seg_b_r <= use_b ? seg_now : 8'h00;
			oe_a_r <= use_a && drive_on;
			oe_b_r <= use_b && drive_on;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_reset_clears_opctl: assert property (@(posedge aclk)
		(aresetn && !$past(aresetn)) |-> (opctl_r == 8'h00 && mode == mode_power_down))
		else $error("operating-mode register not clear after reset");
	a_powerdown_write_ok: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == mode_power_down && wr_sel && wr_addr == `RFMC_OFS_IOCFG1) |=> iocfg1_r == $past(wr_byte))
		else $error("register write lost in power-down");
	a_osc_bit_ready: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(opctl_r[7]) |-> (osc_reg_en && mode == mode_ready))
		else $error("oscillator bit did not enter ready mode");
	a_osc_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.osc_ready |=> (flag_r[0] && irq))
		else $error("oscillator stable event gave no interrupt");
	a_wake_only_mode: assert property (@(posedge aclk) disable iff (!aresetn)
		(opctl_r == 8'h04) |-> (rc_osc_en && mode == mode_wakeup))
		else $error("wake-up bit alone did not select wake-up mode");
	a_wake_irq_raise: assert property (@(posedge aclk) disable iff (!aresetn)
		tif.wake_hit |=> (flag_r[1] && irq))
		else $error("wake-up difference gave no interrupt");
	a_single_one_out: assert property (@(posedge aclk) disable iff (!aresetn)
		(tx_active && iocfg1_r[0]) |=> !(oe_a_r && oe_b_r) && (seg_a_r == 8'h00 || seg_b_r == 8'h00))
		else $error("single-driver mode drives both outputs");
	a_ook_tristate: assert property (@(posedge aclk) disable iff (!aresetn)
		(modulated && auxdef_r[1:0] == 2'b10) |=> (!oe_a_r && !oe_b_r && seg_a_r == 8'h00))
		else $error("fast decay did not release the drivers");
	a_mask_expiry_open: assert property (@(posedge aclk) disable iff (!aresetn)
		(tif.mask_expired && !cmd_mask && !tx_frame_done) |=> rx_on)
		else $error("mask timer expiry did not open receive window");
	a_cmd_window: assert property (@(posedge aclk) disable iff (!aresetn)
		(cmd_mask |=> !rx_on) and ((cmd_unmask && !cmd_mask) |=> rx_on))
		else $error("receive window ignored a mask command");
endmodule

// *** rtl/rfmc_params.svh ***
// Register offsets, field positions, reset values and timing counts of the mode control block.
`ifndef RFMC_PARAMS_SVH
`define RFMC_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define RFMC_OFS_OPCTL 8'h00
`define RFMC_OFS_IOCFG1 8'h04
`define RFMC_OFS_IOCFG2 8'h08
`define RFMC_OFS_AUXDEF 8'h0C
`define RFMC_OFS_NORMLVL 8'h10
`define RFMC_OFS_AMDEPTH 8'h14
`define RFMC_OFS_RXCFG1 8'h18
`define RFMC_OFS_RXCFG2 8'h1C
`define RFMC_OFS_CMD 8'h20
`define RFMC_OFS_MASKTMR 8'h24
`define RFMC_OFS_WAKETMR 8'h28
`define RFMC_OFS_STATUS 8'h2C
// ****************************************
// Field positions
// ****************************************
`define RFMC_OP_OSC_EN 7
`define RFMC_OP_RX_EN 6
`define RFMC_OP_RX_CHN 5
`define RFMC_OP_RX_MAN 4
`define RFMC_OP_TX_EN 3
`define RFMC_OP_WAKEUP 2
`define RFMC_IO1_SINGLE 0
`define RFMC_IO1_ALT_OUT 1
`define RFMC_IO2_SLOW_UP 0
`define RFMC_AUX_MOD_AM 0
`define RFMC_AUX_FAST_DECAY 1
`define RFMC_RX1_MIXER 7
`define RFMC_RX2_LF_EXT 0
`define RFMC_CMD_MASK 0
`define RFMC_CMD_UNMASK 1
`define RFMC_CMD_CALIB 2
`define RFMC_ST_OSC_FLAG 0
`define RFMC_ST_WAKE_FLAG 1
// ****************************************
// Reset values
// ****************************************
`define RFMC_RST_OPCTL 8'h00
`define RFMC_RST_NORMLVL 8'hFF
`define RFMC_RST_AMLVL 8'hFF
`define RFMC_RST_ZERO 8'h00
// ****************************************
// Timing
// ****************************************
`define RFMC_CLK_PERIOD_NS 50
`define RFMC_WAKE_UNIT_NS 100000
`define RFMC_WAKE_UNIT_CYC (`RFMC_WAKE_UNIT_NS / `RFMC_CLK_PERIOD_NS)
`endif

// *** rtl/rfmc_pkg.sv ***
// Types shared by the mode control block.
package rfmc_pkg;
	typedef enum logic [1:0] {
		mode_power_down,
		mode_ready,
		mode_wakeup
	} rfmc_mode_t;
	typedef logic [7:0] rfmc_byte_t;
endpackage

// *** rtl/rfmc_timer_unit.sv ***
// Pin synchronisers, oscillator settle detect, wake-up timer and mask receive timer.
`timescale 1ns/1ps
`include "rfmc_params.svh"
module rfmc_timer_unit
	import rfmc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	rfmc_tmr_if.tmr t
);
	logic [2:0] sync_r [2];
	logic [1:0] pin_q_r;
	logic osc_stable_r;
	logic wake_prev_r;
	logic [11:0] presc_r;
	logic [7:0] period_cnt_r;
	logic meas_start_r;
	logic [7:0] mask_cnt_r;
	logic mask_run_r;
	logic mask_exp_r;
	logic unit_tick;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// A pin level is accepted only when the second and third stages agree.
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync_r[gi] <= 3'h0;
					pin_q_r[gi] <= 1'b0;
				end else begin
					sync_r[gi] <= {sync_r[gi][1:0], t.pin_in[gi]};
					if (sync_r[gi][1] == sync_r[gi][2])
						pin_q_r[gi] <= sync_r[gi][2];
				end
			end
		end
	endgenerate

	// ****************************************
	// Oscillator settle and wake-up detection
	// ****************************************
	// The ready event fires once, on the first cycle the amplitude is seen good while enabled.
	assign t.osc_ready = t.osc_en && pin_q_r[0] && !osc_stable_r;
	assign t.osc_stable = osc_stable_r;
	assign t.wake_hit = t.wake_mode && pin_q_r[1] && !wake_prev_r;
	assign unit_tick = (presc_r == 12'(`RFMC_WAKE_UNIT_CYC - 1));
	assign t.wake_meas_start = meas_start_r;
	assign t.mask_expired = mask_exp_r;

	// Wake-up period counts in fixed units so a byte covers a useful span.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_stable_r <= 1'b0;
			wake_prev_r <= 1'b0;
			presc_r <= 12'h000;
			period_cnt_r <= 8'h00;
			meas_start_r <= 1'b0;
		end else begin
			osc_stable_r <= t.osc_en && pin_q_r[0];
			wake_prev_r <= pin_q_r[1];
			presc_r <= (!t.wake_mode || unit_tick) ? 12'h000 : presc_r + 12'h001;
			meas_start_r <= t.wake_mode && unit_tick && (period_cnt_r == t.wake_period);
			if (!t.wake_mode || (unit_tick && period_cnt_r == t.wake_period))
				period_cnt_r <= 8'h00;
			else if (unit_tick)
				period_cnt_r <= period_cnt_r + 8'h01;
		end
	end

	// ****************************************
	// Mask receive timer
	// ****************************************
	// A restart while running reloads the count; expiry is a single-cycle pulse.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_cnt_r <= 8'h00;
			mask_run_r <= 1'b0;
			mask_exp_r <= 1'b0;
		end else begin
			mask_exp_r <= mask_run_r && !t.mask_start && (mask_cnt_r == 8'h00);
			if (t.mask_start) begin
				mask_cnt_r <= t.mask_len;
				mask_run_r <= 1'b1;
			end else if (mask_run_r) begin
				if (mask_cnt_r == 8'h00)
					mask_run_r <= 1'b0;
				else
					mask_cnt_r <= mask_cnt_r - 8'h01;
			end
		end
	end
endmodule

// *** rtl/rfmc_tmr_if.sv ***
// Carrier between the mode control core and its timer unit.
`timescale 1ns/1ps
interface rfmc_tmr_if;
	logic osc_en;
	logic wake_mode;
	logic [7:0] wake_period;
	logic [7:0] mask_len;
	logic mask_start;
	logic [1:0] pin_in;
	logic osc_stable;
	logic osc_ready;
	logic wake_meas_start;
	logic wake_hit;
	logic mask_expired;
	modport ctl (output osc_en, wake_mode, wake_period, mask_len, mask_start, pin_in,
		input osc_stable, osc_ready, wake_meas_start, wake_hit, mask_expired);
	modport tmr (input osc_en, wake_mode, wake_period, mask_len, mask_start, pin_in,
		output osc_stable, osc_ready, wake_meas_start, wake_hit, mask_expired);
endinterface

// *** testbench/rfmc_front_model.sv ***
// Behavioural model of the analog and framing side facing the mode control block.
`timescale 1ns/1ps
module rfmc_front_model(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic osc_reg_en,
	input wire logic wake_meas_start,
	input wire logic mod_req,
	input wire logic frame_req,
	input wire logic diff_req,
	output logic osc_amp_ok,
	output logic wake_meas_differs,
	output logic tx_mod,
	output logic tx_frame_done,
	output logic rx_pick_pm
);
	// ****************************************
	// Model
	// ****************************************
	logic [3:0] settle_r;
	// oscillator, measurement, framing.
	// The crystal needs sixteen cycles to settle, so the flag cannot come early by accident.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			settle_r <= 4'h0;
			osc_amp_ok <= 1'b0;
			wake_meas_differs <= 1'b0;
			tx_mod <= 1'b0;
			tx_frame_done <= 1'b0;
			rx_pick_pm <= 1'b0;
		end else begin
			settle_r <= osc_reg_en ? settle_r + {3'h0, settle_r != 4'hF} : 4'h0;
			osc_amp_ok <= osc_reg_en && settle_r == 4'hF;
			if (wake_meas_start) begin
				wake_meas_differs <= diff_req; // A result only changes when a measurement is taken.
			end
			tx_mod <= mod_req;
			tx_frame_done <= frame_req;
			rx_pick_pm <= ~rx_pick_pm;
		end
	end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench of the mode control block.
`timescale 1ns/1ps
`include "rfmc_params.svh"
module tb;
	import rfmc_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, mod_req = 0, frame_req = 0, diff_req = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, v;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_amp_ok;
	logic wake_meas_differs, tx_mod, tx_frame_done, rx_pick_pm, osc_reg_en, rc_osc_en, wake_meas_start;
	logic rx_power_en, am_chan_en, pm_chan_en, rx_use_pm, demod_mixer_sel, lf_ext_route, rx_on;
	logic driver_regulated_supply_slow, antenna_driver_out_a_oe, antenna_driver_out_b_oe, irq;
	logic [7:0] antenna_driver_out_a, antenna_driver_out_b;
	int error_cnt = 0, tests_run = 0;
	always #25 aclk = ~aclk;
	rfmc_mode_ctrl i_dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .osc_amp_ok, .wake_meas_differs, .tx_mod, .tx_frame_done, .rx_pick_pm,
		.osc_reg_en, .rc_osc_en, .wake_meas_start, .rx_power_en, .am_chan_en, .pm_chan_en, .rx_use_pm,
		.demod_mixer_sel, .lf_ext_route, .rx_on, .driver_regulated_supply_slow, .antenna_driver_out_a,
		.antenna_driver_out_a_oe, .antenna_driver_out_b, .antenna_driver_out_b_oe, .irq);
	rfmc_front_model i_front(.aclk, .aresetn, .osc_reg_en, .wake_meas_start, .mod_req, .frame_req,
		.diff_req, .osc_amp_ok, .wake_meas_differs, .tx_mod, .tx_frame_done, .rx_pick_pm);
	// ****************************************
	// Tasks
	// ****************************************
	task summarize;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Bus cycles hold every channel until its own handshake edge.
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (1'b1) begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				s_axi_bready <= 1'b0;
				chk("bresp", {6'h0, er}, {6'h0, s_axi_bresp});
				break;
			end
			if (n > 100) begin
				error_cnt++;
				summarize();
			end
		end
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (1) begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata[7:0];
				s_axi_rready <= 1'b0;
				chk("rresp", 8'h00, {6'h0, s_axi_rresp});
				break;
			end
			if (n > 100) begin
				error_cnt++;
				summarize();
			end
		end
	endtask
	// Waits a bounded time for irq (s=0) or the receive window (s=1).
	task wsig(input int s, input int lim);
		int n;
		n = 0;
		while ((s == 0 ? irq : rx_on) !== 1'b1 && n < lim) begin
			@(posedge aclk);
			n++;
		end
		chk(s == 0 ? "irq" : "rx_on", 8'h01, {7'h0, s == 0 ? irq : rx_on});
		if ((s == 0 ? irq : rx_on) !== 1'b1) summarize();
	endtask
	task modo(input logic m, input logic [7:0] aux);
		wr(`RFMC_OFS_AUXDEF, aux, 2'b00);
		@(posedge aclk);
		mod_req <= m;
		repeat (3) @(posedge aclk);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		v = $urandom(11);
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`RFMC_OFS_OPCTL, v);
		chk("opctl", 8'h00, v);
		rd(`RFMC_OFS_NORMLVL, v);
		chk("normlvl", 8'hFF, v);
		wr(`RFMC_OFS_IOCFG1, 8'h01, 2'b00);
		rd(`RFMC_OFS_IOCFG1, v);
		chk("iocfg1", 8'h01, v);
		wr(8'h30, 8'h5A, 2'b10);
		wr(`RFMC_OFS_OPCTL, 8'h88, 2'b00);
		chk("osc_reg_en", 8'h01, {7'h0, osc_reg_en});
		wsig(0, 200);
		wr(`RFMC_OFS_STATUS, 8'h01, 2'b00);
		v = $urandom;
		wr(`RFMC_OFS_NORMLVL, v, 2'b00);
		wr(`RFMC_OFS_IOCFG1, 8'h00, 2'b00);
		modo(1'b0, 8'h00);
		chk("seg_a", v, antenna_driver_out_a);
		chk("oe", 8'h03, {6'h0, antenna_driver_out_a_oe, antenna_driver_out_b_oe});
		wr(`RFMC_OFS_IOCFG1, 8'h03, 2'b00);
		modo(1'b0, 8'h00);
		chk("oe", 8'h01, {6'h0, antenna_driver_out_a_oe, antenna_driver_out_b_oe});
		modo(1'b1, 8'h02);
		chk("oe_b", 8'h00, {7'h0, antenna_driver_out_b_oe});
		modo(1'b1, 8'h00);
		chk("ook", 8'h01, {antenna_driver_out_b[6:0], antenna_driver_out_b_oe});
		wr(`RFMC_OFS_AMDEPTH, 8'h0F, 2'b00);
		wr(`RFMC_OFS_CMD, 8'h04, 2'b00);
		modo(1'b1, 8'h01);
		chk("am", v & 8'hF0, antenna_driver_out_b);
		modo(1'b0, 8'h01);
		chk("norm", v, antenna_driver_out_b);
		wr(`RFMC_OFS_CMD, 8'h02, 2'b00);
		wr(`RFMC_OFS_CMD, 8'h01, 2'b00);
		chk("rx_on", 8'h00, {7'h0, rx_on});
		wr(`RFMC_OFS_CMD, 8'h02, 2'b00);
		chk("rx_on", 8'h01, {7'h0, rx_on});
		wr(`RFMC_OFS_MASKTMR, 8'h05, 2'b00);
		@(posedge aclk);
		frame_req <= 1'b1;
		@(posedge aclk);
		frame_req <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("rx_on", 8'h00, {7'h0, rx_on});
		wsig(1, 20);
		repeat (4) begin
			v = $urandom;
			wr(`RFMC_OFS_RXCFG1, v, 2'b00);
			wr(`RFMC_OFS_RXCFG2, v, 2'b00);
			wr(`RFMC_OFS_OPCTL, {1'b1, v[6], v[5], v[4], v[3], 3'b000}, 2'b00);
			chk("rx", {v[7], v[0], v[6]}, {demod_mixer_sel, lf_ext_route, rx_power_en});
			chk("chan", {v[6], v[6] & v[5], v[6] & v[5] & !v[4] & rx_pick_pm}, {am_chan_en, pm_chan_en, rx_use_pm});
		end
		wr(`RFMC_OFS_RXCFG1, 8'h80, 2'b00);
		chk("mixer", 8'h01, {7'h0, demod_mixer_sel});
		wr(`RFMC_OFS_OPCTL, 8'h80, 2'b00);
		wr(`RFMC_OFS_IOCFG2, 8'h01, 2'b00);
		chk("slow", 8'h01, {7'h0, driver_regulated_supply_slow});
		repeat (40000) @(posedge aclk);
		wr(`RFMC_OFS_OPCTL, 8'h88, 2'b00);
		wr(`RFMC_OFS_IOCFG2, 8'h00, 2'b00);
		wr(`RFMC_OFS_STATUS, 8'h03, 2'b00);
		wr(`RFMC_OFS_OPCTL, 8'h04, 2'b00);
		chk("wake", 8'h02, {6'h0, rc_osc_en, irq});
		@(posedge aclk);
		diff_req <= 1'b1;
		wsig(0, 6000);
		summarize();
	end
endmodule
